// *** verilog/iopl_params.svh ***
`ifndef IOPL_PARAMS_SVH
`define IOPL_PARAMS_SVH

// Register map: index selects port, kind in the high bits
`define IOPL_ADDR_W        8
`define IOPL_DATA_W        8
`define IOPL_NPORTS        4
`define IOPL_KIND_LSB      4
`define IOPL_KIND_DATA     4'h0
`define IOPL_KIND_DIR      4'h1
`define IOPL_KIND_PULL     4'h2
`define IOPL_KIND_RMW      4'h3
`define IOPL_SEGDIS_ADDR   8'h40
`define IOPL_RMWCTL_ADDR   8'h41
`define IOPL_STATUS_ADDR   8'h42
`define IOPL_RESET_LATCH   8'h00
`define IOPL_RESET_DIR     8'h00
`define IOPL_RESET_PULL    8'h00
`define IOPL_RESET_SEGDIS  8'h00
`define IOPL_RESET_RMWCTL  8'h00
`define IOPL_PERIPH_PORTS  4'h2
`define IOPL_OPEN_DRAIN    4'h4

`endif

// *** verilog/iopl_pkg.sv ***
package iopl_pkg;
	typedef logic [7:0] iopl_byte_type;

	typedef struct packed
	{
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} iopl_bus_type;

	typedef enum logic [1:0]
	{
		IOPL_RMW_CLR,
		IOPL_RMW_SET,
		IOPL_RMW_INV,
		IOPL_RMW_NONE
	} iopl_rmw_op_type;
endpackage

// *** verilog/iopl_port_pins.sv ***
`timescale 1ns/1ps
`include "iopl_params.svh"

module iopl_port_pins
	import iopl_pkg::*;
#(
	parameter bit OPEN_DRAIN = 1'b0
)
(
	// Clock and reset
	input  wire logic          clk,
	input  wire logic          reset_n,
	// Port state
	input  wire iopl_byte_type latch,
	input  wire logic          is_output,
	input  wire iopl_byte_type pull_sel,
	input  wire logic          seg_disable,
	// Pin side
	output iopl_byte_type      pin_out,
	output iopl_byte_type      pin_oe,
	output iopl_byte_type      pull_en
);
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			pin_out <= 8'h00;
			pin_oe  <= 8'h00;
			pull_en <= 8'h00;
		end
		else
		begin
			// Open drain only sinks; a latch 1 leaves the pin floating
			pin_out <= OPEN_DRAIN ? 8'h00 : latch;
			pin_oe  <= is_output ? (OPEN_DRAIN ? ~latch : 8'hff) : 8'h00;
			// Pull-ups only where the pin is an input and segment drive is off
			pull_en <= (!is_output && seg_disable) ? pull_sel : 8'h00;
		end
	end
endmodule

// *** verilog/iopl_rmw_merge.sv ***
`timescale 1ns/1ps
`include "iopl_params.svh"

module iopl_rmw_merge
	import iopl_pkg::*;
(
	// Inputs
	input  wire iopl_byte_type   read_value,
	input  wire iopl_rmw_op_type op,
	input  wire logic [2:0]      bit_sel,
	// Result
	output iopl_byte_type        result
);
	// Untargeted bits take whatever a read returned, not the old latch
	always_comb
	begin
		result = read_value;
		case (op)
			IOPL_RMW_CLR: result[bit_sel] = 1'b0;
			IOPL_RMW_SET: result[bit_sel] = 1'b1;
			IOPL_RMW_INV: result[bit_sel] = ~read_value[bit_sel];
			default:      result = read_value;
		endcase
	end
endmodule

// *** verilog/iopl_io_port.sv ***
// Implementation choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
`include "iopl_params.svh"

module iopl_io_port
	import iopl_pkg::*;
(
	// Clock and reset
	input  wire logic                                MCLK,
	input  wire logic                                RESET_N,
	// Register port
	input  wire logic [`IOPL_ADDR_W-1:0]             ADDR,
	input  wire logic [`IOPL_DATA_W-1:0]             WDATA,
	input  wire logic                                WR,
	input  wire logic                                RD,
	output logic [`IOPL_DATA_W-1:0]                  RDATA,
	// Pins
	input  wire logic [`IOPL_NPORTS*8-1:0]           PIN_IN,
	output logic [`IOPL_NPORTS*8-1:0]                PIN_OUT,
	output logic [`IOPL_NPORTS*8-1:0]                PIN_OE,
	output logic [`IOPL_NPORTS*8-1:0]                PULL_EN,
	// Peripheral functions sharing the pins
	input  wire logic [`IOPL_NPORTS*8-1:0]           PERIPH_OUT,
	input  wire logic [`IOPL_NPORTS-1:0]             PERIPH_SEL
);
	iopl_bus_type               bus;
	iopl_byte_type              latch     [`IOPL_NPORTS];
	logic [`IOPL_NPORTS-1:0]    dir_out;
	iopl_byte_type              pull_sel  [`IOPL_NPORTS];
	logic                       seg_disable;
	iopl_byte_type              readback  [`IOPL_NPORTS];
	iopl_byte_type              merged;
	iopl_byte_type              next_rdata;
	iopl_rmw_op_type            rmw_op;
	logic [2:0]                 rmw_bit;
	logic [3:0]                 kind;
	logic [1:0]                 port_idx;
	logic                       in_port_space;
	// Port masks as vectors so each generate pass can pick its own bit
	localparam logic [3:0]      periph_ports = `IOPL_PERIPH_PORTS;
	localparam logic [3:0]      od_ports     = `IOPL_OPEN_DRAIN;

	assign bus           = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};
	assign kind          = bus.addr[7:`IOPL_KIND_LSB];
	assign port_idx      = bus.addr[1:0];
	assign in_port_space = (bus.addr[3:2] == 2'b00) && (kind <= `IOPL_KIND_RMW);

	// Per-port read value and pin driver
	genvar g;
	generate
		for (g = 0; g < `IOPL_NPORTS; g++)
		begin : gen_port
			always_comb
			begin
				if (!dir_out[g])
					readback[g] = PIN_IN[g*8 +: 8];
				else if (periph_ports[g] && PERIPH_SEL[g])
					readback[g] = PERIPH_OUT[g*8 +: 8];
				else
					readback[g] = latch[g];
			end

			iopl_port_pins #(
				.OPEN_DRAIN (od_ports[g])
			) u_pins (
				.clk         (MCLK),
				.reset_n     (RESET_N),
				.latch       (latch[g]),
				.is_output   (dir_out[g]),
				.pull_sel    (pull_sel[g]),
				.seg_disable (seg_disable),
				.pin_out     (PIN_OUT[g*8 +: 8]),
				.pin_oe      (PIN_OE[g*8 +: 8]),
				.pull_en     (PULL_EN[g*8 +: 8])
			);
		end
	endgenerate

	// A bit operation on the port: data[2:0] picks the bit, data[5:4] the operation
	always_comb
	begin
		rmw_bit = bus.wdata[2:0];
		case (bus.wdata[5:4])
			2'h0:    rmw_op = IOPL_RMW_CLR;
			2'h1:    rmw_op = IOPL_RMW_SET;
			2'h2:    rmw_op = IOPL_RMW_INV;
			default: rmw_op = IOPL_RMW_NONE;
		endcase
	end

	iopl_rmw_merge u_merge (
		.read_value (readback[port_idx]),
		.op         (rmw_op),
		.bit_sel    (rmw_bit),
		.result     (merged)
	);

	// Data latches
	always_ff @(posedge MCLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			for (int i = 0; i < `IOPL_NPORTS; i++)
				latch[i] <= `IOPL_RESET_LATCH;
		end
		else if (bus.wr && in_port_space)
		begin
			if (kind == `IOPL_KIND_DATA)
				latch[port_idx] <= bus.wdata;
			else if (kind == `IOPL_KIND_RMW)
				latch[port_idx] <= merged;
		end
	end

	// Direction: one bit per port covers the whole byte; any nonzero store makes it output
	always_ff @(posedge MCLK or negedge RESET_N)
	begin
		if (!RESET_N)
			dir_out <= '0;
		else if (bus.wr && in_port_space && kind == `IOPL_KIND_DIR)
			dir_out[port_idx] <= |bus.wdata;
	end

	// Pull-up selection
	always_ff @(posedge MCLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			for (int i = 0; i < `IOPL_NPORTS; i++)
				pull_sel[i] <= `IOPL_RESET_PULL;
		end
		else if (bus.wr && in_port_space && kind == `IOPL_KIND_PULL)
			pull_sel[port_idx] <= bus.wdata;
	end

	// Segment-output disable
	always_ff @(posedge MCLK or negedge RESET_N)
	begin
		if (!RESET_N)
			seg_disable <= 1'b0;
		else if (bus.wr && bus.addr == `IOPL_SEGDIS_ADDR)
			seg_disable <= bus.wdata[0];
	end

	// Read mux; direction reads return zero; dir_out reads back only at the status address
	always_comb
	begin
		next_rdata = 8'h00;
		if (in_port_space)
		begin
			case (kind)
				`IOPL_KIND_DATA: next_rdata = readback[port_idx];
				`IOPL_KIND_PULL: next_rdata = pull_sel[port_idx];
				default:         next_rdata = 8'h00;
			endcase
		end
		else if (bus.addr == `IOPL_SEGDIS_ADDR)
			next_rdata = {7'h00, seg_disable};
		else if (bus.addr == `IOPL_STATUS_ADDR)
			next_rdata = {4'h0, dir_out};
	end

	// Data stand only in the cycle after the read strobe
	always_ff @(posedge MCLK or negedge RESET_N)
	begin
		if (!RESET_N)
			RDATA <= 8'h00;
		else if (bus.rd)
			RDATA <= next_rdata;
		else
			RDATA <= 8'h00;
	end
endmodule

// *** verif/iopl_io_port_properties.sv ***
`timescale 1ns/1ps
module iopl_io_port_properties
(
	// Clock and reset
	input wire logic        MCLK,
	input wire logic        RESET_N,
	// Register port
	input wire logic [7:0]  ADDR,
	input wire logic [7:0]  WDATA,
	input wire logic        WR,
	input wire logic        RD,
	input wire logic [7:0]  RDATA,
	// Pins
	input wire logic [31:0] PIN_OUT,
	input wire logic [31:0] PIN_OE,
	input wire logic [31:0] PULL_EN
);
	default clocking @(posedge MCLK); endclocking
	default disable iff (!RESET_N);
	dir_out_a: assert property (WR && ADDR == 8'h10 && WDATA != 8'h00 |-> ##2 PIN_OE[7:0] == 8'hff)
		else $error("port0 not driven");
	dir_in_a: assert property (WR && ADDR == 8'h10 && WDATA == 8'h00 |-> ##2 PIN_OE[7:0] == 8'h00)
		else $error("port0 still driven");
	oe_byte_a: assert property (PIN_OE[31:24] inside {8'h00, 8'hff} && PIN_OE[15:8] inside {8'h00, 8'hff})
		else $error("split direction");
	dir_read_a: assert property (RD && ADDR[7:4] == 4'h1 |=> RDATA == 8'h00)
		else $error("direction readable");
	pull_gate_a: assert property ((PULL_EN & PIN_OE) == 32'h0)
		else $error("pull on driven pin");
	od_low_a: assert property (PIN_OUT[23:16] == 8'h00)
		else $error("open drain drives high");
	reset_in_a: assert property ($rose(RESET_N) |-> PIN_OE == 32'h0 && PULL_EN == 32'h0)
		else $error("not input after reset");
	latch_drv_a: assert property (WR && ADDR == 8'h00 && PIN_OE[7:0] == 8'hff |-> ##2 PIN_OUT[7:0] == $past(WDATA, 2))
		else $error("latch not driven");
endmodule

// *** verif/iopl_pin_board.sv ***
`timescale 1ns/1ps
module iopl_pin_board
(
	// Device side
	input wire logic [31:0] pin_out,
	input wire logic [31:0] pin_oe,
	input wire logic [31:0] pull_en,
	// Board drive; undriven pins sink through a weak pull-down
	input wire logic [31:0] ext_val,
	input wire logic [31:0] ext_en,
	output logic [31:0]     pin_in
);
	// The on-chip pull-up beats the weak board pull-down
	always_comb
		for (int i = 0; i < 32; i++)
			pin_in[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_val[i] : pull_en[i];
endmodule

// *** verif/iopl_io_port_test.sv ***
`timescale 1ns/1ps
module iopl_io_port_test;
	logic        mclk, reset_n, wr, rd;
	logic [7:0]  addr, wdata, rdata;
	logic [31:0] pin_in, pin_out, pin_oe, pull_en, periph_out, ext_val, ext_en;
	logic [3:0]  periph_sel;
	int          n_mismatch, n_checks, cycles;

	iopl_io_port dut_u (.MCLK(mclk), .RESET_N(reset_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
		.PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe), .PULL_EN(pull_en), .PERIPH_OUT(periph_out),
		.PERIPH_SEL(periph_sel));
	iopl_pin_board board_u (.pin_out(pin_out), .pin_oe(pin_oe), .pull_en(pull_en), .ext_val(ext_val),
		.ext_en(ext_en), .pin_in(pin_in));

	initial
	begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	task automatic check(input string name, input logic [31:0] exp, got);
		n_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic wr_reg(input logic [7:0] a, d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd_reg(input logic [7:0] a, exp);
		@(posedge mclk);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		#1 check("rdata", exp, rdata);
	endtask

	// Pins follow a register two edges after the strobe
	task automatic settle;
		repeat (2) @(posedge mclk);
		#1;
	endtask

	task automatic t_reset;
		check("oe", 32'h0, pin_oe);
		check("pull", 32'h0, pull_en);
		rd_reg(8'h00, 8'h5a);
		rd_reg(8'h10, 8'h00);
		rd_reg(8'h50, 8'h00);
		wr_reg(8'h00, 8'h33);
		settle();
		check("oe0", 8'h00, pin_oe[7:0]);
		rd_reg(8'h00, 8'h5a);
		wr_reg(8'h10, 8'h01);
		settle();
		check("oe0", 8'hff, pin_oe[7:0]);
		check("out0", 8'h33, pin_out[7:0]);
		rd_reg(8'h00, 8'h33);
		wr_reg(8'h00, 8'ha5);
		settle();
		check("out0", 8'ha5, pin_out[7:0]);
		check("rdata_idle", 8'h00, rdata);
		$display("t_reset done");
	endtask

	task automatic t_rmw;
		logic [7:0] op [4] = '{8'h14, 8'h20, 8'h01, 8'h30};
		logic [7:0] ex [4] = '{8'h1f, 8'h1e, 8'h1c, 8'h1c};
		wr_reg(8'h03, 8'h0f);
		wr_reg(8'h13, 8'hff);
		for (int i = 0; i < 4; i++)
		begin
			wr_reg(8'h33, op[i]);
			settle();
			check("bitop", ex[i], pin_out[31:24]);
		end
		wr_reg(8'h13, 8'h00);
		wr_reg(8'h33, 8'h00);
		wr_reg(8'h13, 8'hff);
		settle();
		check("out3", 8'hc2, pin_out[31:24]);
		periph_sel <= 4'h2;
		periph_out <= 32'h0000_3c00;
		wr_reg(8'h01, 8'h00);
		wr_reg(8'h11, 8'hff);
		rd_reg(8'h01, 8'h3c);
		wr_reg(8'h31, 8'h17);
		@(posedge mclk);
		periph_sel <= 4'h0;
		settle();
		check("out1", 8'hbc, pin_out[15:8]);
		$display("t_rmw done");
	endtask

	task automatic t_pins;
		wr_reg(8'h02, 8'h0f);
		wr_reg(8'h12, 8'hff);
		settle();
		check("oe2", 8'hf0, pin_oe[23:16]);
		rd_reg(8'h02, 8'h0f);
		wr_reg(8'h20, 8'hff);
		wr_reg(8'h40, 8'h01);
		settle();
		check("pull0", 8'h00, pull_en[7:0]);
		wr_reg(8'h10, 8'h00);
		ext_en <= 32'hffff_ff00;
		settle();
		check("pull0", 8'hff, pull_en[7:0]);
		rd_reg(8'h00, 8'hff);
		wr_reg(8'h40, 8'h00);
		settle();
		check("pull0", 8'h00, pull_en[7:0]);
		rd_reg(8'h40, 8'h00);
		rd_reg(8'h42, 8'h0e);
		$display("t_pins done");
	endtask

	task automatic conclude;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			n_mismatch++;
			conclude();
		end
	end

	initial
	begin
		{wr, rd, addr, wdata, periph_sel, periph_out, n_mismatch, n_checks, cycles} = '0;
		reset_n = 1'b0;
		ext_en = '1;
		ext_val = 32'hc3a5_965a;
		repeat (3) @(posedge mclk);
		reset_n <= 1'b1;
		t_reset();
		t_rmw();
		t_pins();
		conclude();
	end
endmodule

bind iopl_io_port iopl_io_port_properties chk_u (.MCLK(MCLK), .RESET_N(RESET_N), .ADDR(ADDR), .WDATA(WDATA),
	.WR(WR), .RD(RD), .RDATA(RDATA), .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE), .PULL_EN(PULL_EN));
